// >>> hdl/ocs_clock_ctrl.v
// oscillator control register file, source switch sequencer
`include "ocs_defines.vh"
module ocs_clock_ctrl
(
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // apb
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // configuration fields
    input  wire [2:0]  initial_source_cfg,
    input  wire [1:0]  primary_submode_cfg,
    input  wire        clock_switch_cfg_bit,
    input  wire        switch_enable_cfg,
    // status pins from analog
    input  wire        pll_lock_in,
    input  wire        clock_fail_in,
    input  wire        new_src_ready_in,
    // clock selection outputs
    output reg  [2:0]  source_select,
    output reg  [1:0]  primary_submode,
    output reg         pll_enable,
    output reg         low_power_internal_rc_ref_enable,
    output reg         secondary_osc_enable,
    output reg  [2:0]  rc_div_sel,
    output reg  [4:0]  pre_sel,
    output reg  [1:0]  post_sel,
    output reg  [8:0]  fb_sel,
    output wire [8:0]  rc_div,
    output wire [5:0]  pre_div,
    output wire [3:0]  post_div,
    output wire [9:0]  fb_mul,
    output wire        cpu_div_by_two,
    output reg         fail_safe_active
);
    localparam ST_IDLE   = 2'h0;
    localparam ST_WAIT   = 2'h1;
    localparam ST_SETTLE = 2'h2;

    reg  [2:0]  cur_q;
    reg  [2:0]  new_source_code_q;
    reg         cfg_lock_q;
    reg         cf_q;
    reg         switch_request_q;
    reg  [15:0] clock_divisor_reg_q;
    reg  [15:0] pll_feedback_reg_q;
    reg  [1:0]  unl_q;
    reg  [1:0]  st_q;
    reg  [3:0]  cnt_q;
    reg         por_q;
    wire        lock_s;
    wire        fail_s;
    wire        rdy_s;
    wire        wr;
    wire        unlocked;
    wire        cfg_frozen;
    wire        uses_pll;

    ocs_sync u_sync_lock (.clk_sys(clk_sys), .rst_n(rst_n), .din(pll_lock_in), .dout(lock_s));
    ocs_sync u_sync_fail (.clk_sys(clk_sys), .rst_n(rst_n), .din(clock_fail_in), .dout(fail_s));
    ocs_sync u_sync_rdy  (.clk_sys(clk_sys), .rst_n(rst_n), .din(new_src_ready_in),
                          .dout(rdy_s));

    ocs_div_calc u_div
    (
        .rc_div_sel (rc_div_sel),
        .pre_sel    (pre_sel),
        .post_sel   (post_sel),
        .fb_sel     (fb_sel),
        .rc_div     (rc_div),
        .pre_div    (pre_div),
        .post_div   (post_div),
        .fb_mul     (fb_mul)
    );

    assign pready     = 1'b1;
    assign pslverr    = 1'b0;
    assign wr         = psel & penable & pwrite;
    assign unlocked   = (unl_q == 2'h2);
    assign cfg_frozen = cfg_lock_q & clock_switch_cfg_bit;
    assign uses_pll   = (cur_q == `OCS_SRC_RC_WITH_PLL_MODE) | (cur_q == `OCS_SRC_PRIPLL);
    assign cpu_div_by_two = 1'b1;

    // unlock sequence: two keys then one write
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            unl_q <= 2'h0;
        else if (wr && paddr == `OCS_ADDR_UNLOCK)
        begin
            if (pwdata[15:0] == `OCS_UNLOCK_KEY1)
                unl_q <= 2'h1;
            else if (pwdata[15:0] == `OCS_UNLOCK_KEY2 && unl_q == 2'h1)
                unl_q <= 2'h2;
            else
                unl_q <= 2'h0;
        end
        else if (wr)
            unl_q <= 2'h0;
    end

    // power on capture of configuration
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            por_q           <= 1'b1;
            cur_q           <= `OCS_SRC_DIVN;
            new_source_code_q          <= `OCS_SRC_DIVN;
            primary_submode <= `OCS_PRI_EC;
            cfg_lock_q      <= 1'b0;
            cf_q            <= 1'b0;
            switch_request_q         <= 1'b0;
            clock_divisor_reg_q        <= `OCS_CLOCK_DIVISOR_REG_RST;
            pll_feedback_reg_q        <= `OCS_PLL_FEEDBACK_REG_RST;
            secondary_osc_enable <= 1'b0;
            st_q            <= ST_IDLE;
            cnt_q           <= 4'h0;
        end
        else if (por_q)
        begin
            por_q           <= 1'b0;
            cur_q           <= initial_source_cfg;
            new_source_code_q          <= initial_source_cfg;
            primary_submode <= primary_submode_cfg;
        end
        else
        begin
            if (wr && unlocked && paddr == `OCS_ADDR_OSC)
            begin
                if (!cfg_frozen)
                    new_source_code_q <= pwdata[10:8];
                cfg_lock_q <= cfg_lock_q | pwdata[7];
                secondary_osc_enable <= pwdata[1];
                if (switch_enable_cfg && pwdata[0] && !cfg_frozen)
                    switch_request_q <= 1'b1;
            end
            if (wr && paddr == `OCS_ADDR_CLOCK_DIVISOR_REG && !cfg_frozen)
                clock_divisor_reg_q <= pwdata[15:0] & `OCS_CLOCK_DIVISOR_REG_MASK;
            if (wr && paddr == `OCS_ADDR_PLL_FEEDBACK_REG && !cfg_frozen)
                pll_feedback_reg_q <= pwdata[15:0] & `OCS_PLL_FEEDBACK_REG_MASK;
            // flag: hardware set beats software clear
            if (fail_s)
                cf_q <= 1'b1;
            else if (wr && unlocked && paddr == `OCS_ADDR_OSC && !pwdata[3])
                cf_q <= 1'b0;
            case (st_q)
                ST_IDLE:
                    if (switch_request_q)
                    begin
                        if (new_source_code_q == cur_q)
                            switch_request_q <= 1'b0;
                        else
                            st_q <= ST_WAIT;
                    end
                ST_WAIT:
                    if (rdy_s && (!(new_source_code_q == `OCS_SRC_RC_WITH_PLL_MODE || new_source_code_q == `OCS_SRC_PRIPLL)
                                  || lock_s))
                    begin
                        st_q  <= ST_SETTLE;
                        cnt_q <= `OCS_SETTLE_CYC;
                    end
                ST_SETTLE:
                    if (cnt_q == 4'h1)
                    begin
                        cur_q   <= new_source_code_q;
                        switch_request_q <= 1'b0;
                        st_q    <= ST_IDLE;
                    end
                    else
                        cnt_q <= cnt_q - 4'h1;
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    // registered clock select outputs, updated every clock, also while switching
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            source_select    <= `OCS_SRC_DIVN;
            pll_enable       <= 1'b0;
            low_power_internal_rc_ref_enable  <= 1'b1;
            rc_div_sel       <= 3'h0;
            pre_sel          <= 5'h00;
            post_sel         <= 2'h1;
            fb_sel           <= 9'h030;
            fail_safe_active <= 1'b0;
        end
        else
        begin
            source_select    <= fail_s ? `OCS_SRC_FRC : cur_q;
            pll_enable       <= uses_pll | (st_q != ST_IDLE &&
                                (new_source_code_q == `OCS_SRC_RC_WITH_PLL_MODE || new_source_code_q == `OCS_SRC_PRIPLL));
            low_power_internal_rc_ref_enable  <= 1'b1;
            rc_div_sel       <= clock_divisor_reg_q[10:8];
            pre_sel          <= clock_divisor_reg_q[4:0];
            post_sel         <= clock_divisor_reg_q[7:6];
            fb_sel           <= pll_feedback_reg_q[8:0];
            fail_safe_active <= cf_q | fail_s;
        end
    end

    // read mux
    always @*
    begin
        prdata = 32'h0000_0000;
        case (paddr)
            `OCS_ADDR_OSC:
                prdata[15:0] = {1'b0, cur_q, 1'b0, new_source_code_q, cfg_lock_q, 1'b0,
                                lock_s & pll_enable, 1'b0, cf_q, 1'b0,
                                secondary_osc_enable, switch_request_q};
            `OCS_ADDR_CLOCK_DIVISOR_REG:
                prdata[15:0] = clock_divisor_reg_q;
            `OCS_ADDR_PLL_FEEDBACK_REG:
                prdata[15:0] = pll_feedback_reg_q;
            `OCS_ADDR_UNLOCK:
                prdata[1:0] = unl_q;
            default:
                prdata = 32'h0000_0000;
        endcase
    end
endmodule // ocs_clock_ctrl

// >>> pkg/ocs_defines.vh
// constants of the oscillator clock select block
`ifndef OCS_DEFINES_VH
`define OCS_DEFINES_VH
`define OCS_ADDR_OSC      12'h000
`define OCS_ADDR_CLOCK_DIVISOR_REG   12'h004
`define OCS_ADDR_PLL_FEEDBACK_REG   12'h008
`define OCS_ADDR_UNLOCK   12'h00c
`define OCS_UNLOCK_KEY1   16'h0046
`define OCS_UNLOCK_KEY2   16'h0057
`define OCS_SRC_FRC       3'h0
`define OCS_SRC_RC_WITH_PLL_MODE    3'h1
`define OCS_SRC_PRI       3'h2
`define OCS_SRC_PRIPLL    3'h3
`define OCS_SRC_SEC       3'h4
`define OCS_SRC_LOW_POWER_INTERNAL_RC      3'h5
`define OCS_SRC_DIV16     3'h6
`define OCS_SRC_DIVN      3'h7
`define OCS_PRI_EC        2'h0
`define OCS_PRI_XT        2'h1
`define OCS_PRI_HS        2'h2
`define OCS_RC_SEL_MAX    3'h7
`define OCS_RC_DIV_MAX    9'h100
`define OCS_CLOCK_DIVISOR_REG_RST    16'h0040
`define OCS_PLL_FEEDBACK_REG_RST    16'h0030
`define OCS_CLOCK_DIVISOR_REG_MASK   16'h07df
`define OCS_PLL_FEEDBACK_REG_MASK   16'h01ff
`define OCS_SETTLE_CYC    4'ha
`endif

// >>> hdl/ocs_sync.v
// two flop synchroniser for one level
module ocs_sync
(
    // clock and reset
    input  wire clk_sys,
    input  wire rst_n,
    // level in and out
    input  wire din,
    output wire dout
);
    reg meta_q;
    reg sync_q;
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end
    assign dout = sync_q;
endmodule // ocs_sync

// >>> hdl/ocs_div_calc.v
// divider factors decoded from register fields
`include "ocs_defines.vh"
module ocs_div_calc
(
    // fields
    input  wire [2:0] rc_div_sel,
    input  wire [4:0] pre_sel,
    input  wire [1:0] post_sel,
    input  wire [8:0] fb_sel,
    // factors
    output wire [8:0] rc_div,
    output wire [5:0] pre_div,
    output wire [3:0] post_div,
    output wire [9:0] fb_mul
);
    // top code skips 128 and divides by 256
    assign rc_div   = (rc_div_sel == `OCS_RC_SEL_MAX) ? `OCS_RC_DIV_MAX :
                      (9'h001 << rc_div_sel);
    assign pre_div  = {1'b0, pre_sel} + 6'h02;
    assign post_div = (post_sel == 2'h0) ? 4'h2 :
                      (post_sel == 2'h1) ? 4'h4 : 4'h8;
    assign fb_mul   = {1'b0, fb_sel} + 10'h002;
endmodule // ocs_div_calc

// >>> tb/ocs_checker.sv
// assertions on the oscillator clock select block ports
module ocs_checker
(
    // clock, reset, bus
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // configuration and status
    input wire logic        clock_switch_cfg_bit,
    input wire logic        clock_fail_in,
    input wire logic        fail_safe_active,
    input wire logic [2:0]  source_select,
    input wire logic        low_power_internal_rc_ref_enable,
    input wire logic        cpu_div_by_two,
    // divider fields and factors
    input wire logic [2:0]  rc_div_sel,
    input wire logic [4:0]  pre_sel,
    input wire logic [1:0]  post_sel,
    input wire logic [8:0]  fb_sel,
    input wire logic [8:0]  rc_div,
    input wire logic [5:0]  pre_div,
    input wire logic [3:0]  post_div,
    input wire logic [9:0]  fb_mul
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_fail_held;
        clock_fail_in [*4];
    endsequence
    a_rc_div_map: assert property (rc_div == (rc_div_sel == 3'h7 ? 9'h100 : 9'h1 << rc_div_sel))
        else $error("rc divide factor wrong");
    a_low_power_internal_rc_ref_on: assert property (low_power_internal_rc_ref_enable)
        else $error("low power rc reference off");
    a_cpu_half: assert property (cpu_div_by_two)
        else $error("instruction clock not half");
    a_pre_div_map: assert property (pre_div == {1'b0, pre_sel} + 6'h2)
        else $error("prescale factor wrong");
    a_pre_sel_load: assert property (psel && penable && pwrite && paddr == 12'h004
        && !clock_switch_cfg_bit |-> ##2 pre_sel == $past(pwdata[4:0], 2))
        else $error("prescale not loaded");
    a_fb_mul_map: assert property (fb_mul == {1'b0, fb_sel} + 10'h2)
        else $error("feedback factor wrong");
    a_post_div_map: assert property (post_div == (post_sel == 2'h0 ? 4'h2 :
        post_sel == 2'h1 ? 4'h4 : 4'h8)) else $error("postscale factor wrong");
    a_cur_src_read: assert property (psel && penable && !pwrite && paddr == 12'h000
        && !fail_safe_active |=> fail_safe_active || source_select == $past(prdata[14:12]))
        else $error("current code wrong");
    a_fail_force: assert property (s_fail_held |-> ##[0:2] (source_select == 3'h0
        && fail_safe_active)) else $error("fail safe not taken");
endmodule // ocs_checker

bind ocs_clock_ctrl ocs_checker chk (.*);

// >>> tb/ocs_osc_model.sv
// behavioural model of the oscillators and the pll analog side
module ocs_osc_model
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // bench controls
    input  wire logic start,
    input  wire logic slow,
    input  wire logic fail,
    // block side
    input  wire logic pll_enable,
    output logic      pll_lock_in,
    output logic      new_src_ready_in,
    output logic      clock_fail_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] cnt_q;
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n) cnt_q <= 6'h00;
        else if (start) cnt_q <= 6'h00;
        else if (cnt_q != 6'h3f) cnt_q <= cnt_q + 6'h01;
    end
    // start-up timer, prompt or slow
    assign new_src_ready_in = cnt_q >= (slow ? 6'h28 : 6'h03);
    assign pll_lock_in      = pll_enable && new_src_ready_in;
    assign clock_fail_in    = fail;
endmodule // ocs_osc_model

// >>> tb/tb_top.sv
// self-checking bench for the oscillator clock select block
`include "ocs_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [11:0] a; logic [15:0] w; logic [15:0] r;} ocs_row_t;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, start, slow, fail;
    logic        sw_cfg, sw_en, pll_lock_in, clock_fail_in, new_src_ready_in, pll_enable;
    logic        fail_safe_active, cpu_div_by_two;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0]  init_src, source_select;
    logic [1:0]  init_sub, primary_submode;
    logic [15:0] q;
    logic [8:0]  rc_div;
    logic [5:0]  pre_div;
    logic [3:0]  post_div;
    logic [9:0]  fb_mul;
    int          err_total, num_checks, n;
    ocs_row_t    rows [6] = '{'{12'h004, 16'hffff, 16'h07df}, '{12'h004, 16'h0000, 16'h0000},
        '{12'h008, 16'hffff, 16'h01ff}, '{12'h008, 16'h001e, 16'h001e},
        '{12'h010, 16'hffff, 16'h0000}, '{12'h004, 16'h07df, 16'h07df}};
    ocs_clock_ctrl DUT
    (
        .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .initial_source_cfg(init_src), .primary_submode_cfg(init_sub),
        .clock_switch_cfg_bit(sw_cfg), .switch_enable_cfg(sw_en), .pll_lock_in, .clock_fail_in,
        .new_src_ready_in, .source_select, .primary_submode, .pll_enable, .low_power_internal_rc_ref_enable(),
        .secondary_osc_enable(), .rc_div_sel(), .pre_sel(), .post_sel(), .fb_sel(), .rc_div,
        .pre_div, .post_div, .fb_mul, .cpu_div_by_two, .fail_safe_active
    );
    ocs_osc_model osc (.clk_sys, .rst_n, .start, .slow, .fail, .pll_enable, .pll_lock_in,
        .new_src_ready_in, .clock_fail_in);
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (!pready) @(posedge clk_sys);
        q = prdata[15:0];
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // unlocked write to oscillator control, then read back
    task automatic ow(input logic [15:0] d);
        apb(1'b1, `OCS_ADDR_UNLOCK, `OCS_UNLOCK_KEY1);
        apb(1'b1, `OCS_ADDR_UNLOCK, `OCS_UNLOCK_KEY2);
        apb(1'b1, `OCS_ADDR_OSC, d);
        apb(1'b0, `OCS_ADDR_OSC, 16'h0000);
    endtask
    task automatic rst(input logic [2:0] s, input logic [1:0] m);
        rst_n <= 1'b0; init_src <= s; init_sub <= m;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial
    begin
        #(25 * 20000);
        err_total++;
        conclude();
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, start, slow, fail, sw_cfg} = '0;
        sw_en = 1'b1; rst_n = 1'b0;
        rst(3'h7, 2'h2);
        apb(1'b0, `OCS_ADDR_OSC, 16'h0); chk(q, 16'h7700);
        apb(1'b0, `OCS_ADDR_CLOCK_DIVISOR_REG, 16'h0); chk(q, `OCS_CLOCK_DIVISOR_REG_RST);
        apb(1'b0, `OCS_ADDR_PLL_FEEDBACK_REG, 16'h0); chk(q, `OCS_PLL_FEEDBACK_REG_RST);
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 16'h0); chk(q, rows[i].r);
        end
        chk(rc_div, 9'h100); chk(pre_div, 6'h21); chk(post_div, 4'h8);
        chk(fb_mul, 10'h020); chk(cpu_div_by_two, 1'b1);
        apb(1'b1, `OCS_ADDR_CLOCK_DIVISOR_REG, 16'h0000);
        for (int c = 0; c < 9; c++)
        begin
            slow <= c[0]; start <= 1'b1;
            @(posedge clk_sys);
            start <= 1'b0;
            ow({5'h00, c[2:0] | {3{c[3]}}, 8'h01}); n = 0;
            while (q[0] !== 1'b0 && n++ < 80) apb(1'b0, `OCS_ADDR_OSC, 16'h0);
            chk(q, {1'b0, c[2:0] | {3{c[3]}}, 1'b0, c[2:0] | {3{c[3]}}, 8'h00}
                | ((c == 1 || c == 3) ? 16'h0020 : 16'h0));
            chk(source_select, c[2:0] | {3{c[3]}});
            chk(pll_enable, c == 1 || c == 3);
        end
        apb(1'b1, `OCS_ADDR_OSC, 16'h0201);
        apb(1'b0, `OCS_ADDR_OSC, 16'h0); chk(q, 16'h7700);
        fail <= 1'b1;
        repeat (6) @(posedge clk_sys);
        apb(1'b0, `OCS_ADDR_OSC, 16'h0); chk(q[3], 1'b1); chk(source_select, 3'h0);
        fail <= 1'b0;
        ow(16'h0700); chk(q[3], 1'b0);
        ow(16'h0708); chk(q[3], 1'b0);
        sw_cfg <= 1'b1;
        ow(16'h0780);
        apb(1'b1, `OCS_ADDR_CLOCK_DIVISOR_REG, 16'h0003);
        apb(1'b0, `OCS_ADDR_CLOCK_DIVISOR_REG, 16'h0); chk(q, 16'h0000);
        sw_cfg <= 1'b0;
        apb(1'b1, `OCS_ADDR_CLOCK_DIVISOR_REG, 16'h0003);
        apb(1'b0, `OCS_ADDR_CLOCK_DIVISOR_REG, 16'h0); chk(q, 16'h0003);
        for (int m = 0; m < 3; m++)
        begin
            rst(3'h2, m[1:0]);
            @(posedge clk_sys);
            chk(source_select, 3'h2); chk(primary_submode, m[1:0]);
        end
        conclude();
    end
endmodule // tb_top
